// ==== verilog/capcom_unit.sv ====
// Dual time base, sixteen channel capture/compare unit
// What this block does
// - Sixteen channels, one-cycle resolution, eight cycles when staggered mode is on.
// - Two independent 16-bit timers, each with its own reload register.
// - Timer count from prescaled clock or upstream timer overflow.
// - External count inputs may also clock the timers.
// - Each channel picks its timer and capture or compare use.
// - Each channel owns one pin: capture trigger input or compare output.
// - Capture copies the assigned timer value into the channel register.
// - Every capture raises that channel's interrupt request.
// - Capture edge selectable: rising, falling or both.
// - Compare channels match against their timer; equality starts the mode action.
// - Mode 0: interrupt only on each match, pin untouched.
// - Mode 1: each match toggles the pin.
// - Mode 2: at most one match interrupt per timer period.
// - Mode 3: match sets pin, timer overflow clears it, once per period.
// - Double mode: two registers toggle one pin, many events per period.
// - Single event option limits a channel to one compare event.
`timescale 1ns/1ps
module capcom_unit
  import capcom_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Timer control
  input wire logic [capcom_pkg::TIMERS-1:0] timer_run,
  input wire logic [capcom_pkg::TIMERS-1:0][2:0] timer_src,
  input wire logic [capcom_pkg::TIMERS-1:0][capcom_pkg::TW-1:0] timer_reload,
  input wire logic staggered,
  input wire logic upstream_gp_timer_ovf,
  input wire logic [capcom_pkg::TIMERS-1:0] ext_count,
  // Channel configuration
  input wire logic [capcom_pkg::CHANNELS-1:0][3:0] chan_mode,
  input wire logic [capcom_pkg::CHANNELS-1:0] chan_timer,
  input wire logic [capcom_pkg::CHANNELS-1:0] single_event,
  // Channel register access
  input wire logic wr_en,
  input wire logic [3:0] wr_chan,
  input wire logic [capcom_pkg::TW-1:0] wr_data,
  input wire logic [3:0] rd_chan,
  output logic [capcom_pkg::TW-1:0] rd_data,
  // Channel pins
  input wire logic [capcom_pkg::CHANNELS-1:0] pin_in,
  output logic [capcom_pkg::CHANNELS-1:0] pin_out,
  output logic [capcom_pkg::CHANNELS-1:0] pin_oe_n,
  // Status
  output logic [capcom_pkg::CHANNELS-1:0] chan_irq,
  output logic [capcom_pkg::TIMERS-1:0][capcom_pkg::TW-1:0] timer_value,
  output logic [capcom_pkg::TIMERS-1:0] timer_ovf,
  output logic [capcom_pkg::CHANNELS-1:0] single_done
);
  import capcom_pkg::*;

  // ==========================================================
  // Count source selection

  function automatic logic src_enable(input logic [2:0] src, input logic [DIV_W-1:0] div,
                                      input logic up_ovf, input logic ext_rise);
    logic hit;
    hit = 1'b0;
    if (src == SRC_UPSTREAM)
    begin
      hit = up_ovf;
    end
    else if (src == SRC_EXTERNAL)
    begin
      hit = ext_rise;
    end
    else if (src <= SRC_DIV_MAX)
    begin
      // Divide by 2**src: all low src bits of the free counter set
      hit = 1'b1;
      for (int b = 0; b < DIV_W; b++)
      begin
        if (b < int'(src) && !div[b])
        begin
          hit = 1'b0;
        end
      end
    end
    return hit;
  endfunction

  function automatic logic drives_pin(input logic [3:0] mode, input int idx);
    return (mode == MODE_CMP1) || (mode == MODE_CMP3) ||
           ((mode == MODE_DOUBLE) && (idx < PIN_GROUPS));
  endfunction

  // ==========================================================
  // Time bases

  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic [2:0] phase;
  logic [2:0] next_phase;
  logic [TIMERS-1:0] ext_prev;
  logic [TIMERS-1:0] upd;
  logic [TIMERS-1:0] next_upd;
  logic [TIMERS-1:0] next_timer_ovf;
  logic [TIMERS-1:0][TW-1:0] next_timer_value;

  always_comb
  begin
    next_div_cnt = div_cnt + 5'h01;
    next_phase = phase + 3'h1;
    next_timer_value = timer_value;
    next_upd = '0;
    next_timer_ovf = '0;
    for (int t = 0; t < TIMERS; t++)
    begin
      if (timer_run[t] &&
          src_enable(timer_src[t], div_cnt, upstream_gp_timer_ovf, ext_count[t] & ~ext_prev[t]) &&
          (!staggered || phase == STAGGER_LAST))
      begin
        next_upd[t] = 1'b1;
        if (timer_value[t] == TIMER_TOP)
        begin
          next_timer_value[t] = timer_reload[t];
          next_timer_ovf[t] = 1'b1;
        end
        else
        begin
          next_timer_value[t] = timer_value[t] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_cnt <= DIV_RESET;
      phase <= PHASE_RESET;
      ext_prev <= '0;
      upd <= '0;
      timer_ovf <= '0;
      timer_value <= '0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      phase <= next_phase;
      ext_prev <= ext_count;
      upd <= next_upd;
      timer_ovf <= next_timer_ovf;
      timer_value <= next_timer_value;
    end
  end

  // ==========================================================
  // Channels

  logic [CHANNELS-1:0][TW-1:0] chan_values;
  logic [CHANNELS-1:0] reg_we;
  logic [CHANNELS-1:0][TW-1:0] reg_wdata;
  logic [CHANNELS-1:0] pin_prev;
  logic [CHANNELS-1:0] fired;
  logic [CHANNELS-1:0] next_fired;
  logic [CHANNELS-1:0] next_single_done;
  logic [CHANNELS-1:0] next_chan_irq;
  logic [CHANNELS-1:0] next_pin_out;
  logic [CHANNELS-1:0] next_pin_oe_n;

  always_comb
  begin
    logic t;
    logic rise;
    logic fall;
    logic cap;
    logic hit;
    logic ev;
    logic sw;
    t = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    cap = 1'b0;
    hit = 1'b0;
    ev = 1'b0;
    sw = 1'b0;
    reg_we = '0;
    reg_wdata = '0;
    next_fired = fired;
    next_single_done = single_done;
    next_chan_irq = '0;
    next_pin_out = pin_out;
    next_pin_oe_n = '1;
    for (int i = 0; i < CHANNELS; i++)
    begin
      t = chan_timer[i];
      rise = pin_in[i] & ~pin_prev[i];
      fall = ~pin_in[i] & pin_prev[i];
      sw = wr_en && (wr_chan == 4'(i));
      cap = ((chan_mode[i] == MODE_CAP_RISE) && rise) ||
            ((chan_mode[i] == MODE_CAP_FALL) && fall) ||
            ((chan_mode[i] == MODE_CAP_BOTH) && (rise || fall));
      hit = upd[t] && (timer_value[t] == chan_values[i]) && !single_done[i];
      ev = 1'b0;
      if (sw)
      begin
        reg_we[i] = 1'b1;
        reg_wdata[i] = wr_data;
      end
      // capture wins over a software write
      if (cap)
      begin
        reg_we[i] = 1'b1;
        reg_wdata[i] = timer_value[t];
      end
      if (drives_pin(chan_mode[i], i))
      begin
        next_pin_oe_n[i] = 1'b0;
      end
      case (chan_mode[i])
        MODE_CMP0: ev = hit;
        MODE_CMP1:
        begin
          ev = hit;
          next_pin_out[i] = next_pin_out[i] ^ hit;
        end
        MODE_CMP2: ev = hit && !fired[i];
        // set on match, clear on overflow
        MODE_CMP3:
        begin
          ev = hit && !fired[i];
          if (timer_ovf[t])
          begin
            next_pin_out[i] = 1'b0;
          end
          if (ev)
          begin
            next_pin_out[i] = 1'b1;
          end
        end
        MODE_DOUBLE:
        begin
          ev = hit;
          next_pin_out[i % PIN_GROUPS] = next_pin_out[i % PIN_GROUPS] ^ hit;
        end
        default: ev = 1'b0;
      endcase
      // overflow opens a new period; a match in the same cycle counts only if fired was still clear
      next_fired[i] = ev || (fired[i] && !timer_ovf[t]);
      // one event then hold until rewritten or option dropped
      next_single_done[i] = single_event[i] && (ev || (single_done[i] && !sw));
      next_chan_irq[i] = cap || ev;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_prev <= '0;
      fired <= '0;
      single_done <= '0;
      chan_irq <= '0;
      pin_out <= '0;
      pin_oe_n <= '1;
    end
    else
    begin
      pin_prev <= pin_in;
      fired <= next_fired;
      single_done <= next_single_done;
      chan_irq <= next_chan_irq;
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  // ==========================================================
  // Register array

  channel_regs u_regs (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .we(reg_we),
    .wdata(reg_wdata),
    .rd_sel(rd_chan),
    .values(chan_values),
    .rd_data(rd_data)
  );
endmodule

// ==== verilog/capcom_pkg.sv ====
// Shared constants for the sixteen channel capture/compare unit
package capcom_pkg;
  // ==========================================================
  // Sizes
  localparam int CHANNELS = 16;
  localparam int TIMERS = 2;
  localparam int TW = 16;
  localparam int PIN_GROUPS = 8;
  localparam int DIV_W = 5;
  // ==========================================================
  // Reset values and timer top value
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic [15:0] CHAN_RESET = 16'h0000;
  localparam logic [15:0] TIMER_TOP = 16'hFFFF;
  localparam logic [4:0] DIV_RESET = 5'h00;
  localparam logic [2:0] PHASE_RESET = 3'h0;
  // Staggered mode lets the timers advance only once per eight cycles
  localparam logic [2:0] STAGGER_LAST = 3'h7;
  // ==========================================================
  // Channel mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_RISE = 4'h1;
  localparam logic [3:0] MODE_CAP_FALL = 4'h2;
  localparam logic [3:0] MODE_CAP_BOTH = 4'h3;
  localparam logic [3:0] MODE_CMP0 = 4'h4;
  localparam logic [3:0] MODE_CMP1 = 4'h5;
  localparam logic [3:0] MODE_CMP2 = 4'h6;
  localparam logic [3:0] MODE_CMP3 = 4'h7;
  localparam logic [3:0] MODE_DOUBLE = 4'h8;
  // ==========================================================
  // Timer count sources; codes 0 to 5 divide the clock by 2**code
  localparam logic [2:0] SRC_DIV_MAX = 3'h5;
  localparam logic [2:0] SRC_UPSTREAM = 3'h6;
  localparam logic [2:0] SRC_EXTERNAL = 3'h7;
endpackage

// ==== verilog/channel_regs.sv ====
// Sixteen channel registers with parallel compare view and registered read port
`timescale 1ns/1ps
module channel_regs
  import capcom_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Per-channel writes
  input wire logic [capcom_pkg::CHANNELS-1:0] we,
  input wire logic [capcom_pkg::CHANNELS-1:0][capcom_pkg::TW-1:0] wdata,
  // Read side
  input wire logic [3:0] rd_sel,
  output logic [capcom_pkg::CHANNELS-1:0][capcom_pkg::TW-1:0] values,
  output logic [capcom_pkg::TW-1:0] rd_data
);
  logic [CHANNELS-1:0][TW-1:0] next_values;
  logic [TW-1:0] next_rd_data;

  always_comb
  begin
    next_values = values;
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (we[i])
      begin
        next_values[i] = wdata[i];
      end
    end
    next_rd_data = values[rd_sel];
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      values <= '0;
      rd_data <= CHAN_RESET;
    end
    else
    begin
      values <= next_values;
      rd_data <= next_rd_data;
    end
  end
endmodule

// ==== dv/capcom_checker.sv ====
// Port-level assertions for the capture/compare unit
`timescale 1ns/1ps
module capcom_checker
  import capcom_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Timers
  input wire logic [capcom_pkg::TIMERS-1:0] timer_run,
  input wire logic [capcom_pkg::TIMERS-1:0][capcom_pkg::TW-1:0] timer_reload,
  input wire logic [capcom_pkg::TIMERS-1:0][capcom_pkg::TW-1:0] timer_value,
  input wire logic [capcom_pkg::TIMERS-1:0] timer_ovf,
  // Channels
  input wire logic [capcom_pkg::CHANNELS-1:0][3:0] chan_mode,
  input wire logic [capcom_pkg::CHANNELS-1:0] pin_in,
  input wire logic [capcom_pkg::CHANNELS-1:0] pin_oe_n,
  input wire logic [capcom_pkg::CHANNELS-1:0] chan_irq
);
  // ==========================================================
  // Assertions
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  rise_capture_a: assert property (chan_mode[0] == MODE_CAP_RISE && $rose(pin_in[0]) |=> chan_irq[0])
    else $error("rising capture gave no irq");
  fall_capture_a: assert property (chan_mode[1] == MODE_CAP_FALL && $fell(pin_in[1]) |=> chan_irq[1])
    else $error("falling capture gave no irq");
  rise_only_a: assert property (chan_mode[0] == MODE_CAP_RISE && $fell(pin_in[0]) |=> !chan_irq[0])
    else $error("falling edge captured in rise mode");
  both_edges_a: assert property (chan_mode[2] == MODE_CAP_BOTH && $changed(pin_in[2]) |=> chan_irq[2])
    else $error("edge missed in both-edge mode");
  ovf_reload_a: assert property (timer_ovf[0] |-> timer_value[0] == $past(timer_reload[0]))
    else $error("timer not reloaded on overflow");
  ovf_cause_a: assert property ($rose(timer_ovf[0]) |-> $past(timer_value[0]) == TIMER_TOP)
    else $error("overflow without top value");
  timer_hold_a: assert property (!timer_run[1] |=> $stable(timer_value[1]))
    else $error("stopped timer moved");
  irq_pin_free_a: assert property (chan_mode[3] == MODE_CMP0 && $past(chan_mode[3]) == MODE_CMP0 |-> pin_oe_n[3])
    else $error("mode 0 channel drives its pin");
  toggle_drive_a: assert property (chan_mode[4] == MODE_CMP1 && $past(chan_mode[4]) == MODE_CMP1 |-> !pin_oe_n[4])
    else $error("mode 1 channel not driving");
endmodule
bind capcom_unit capcom_checker chk_u (.ref_clk(ref_clk), .resetn(resetn), .timer_run(timer_run),
  .timer_reload(timer_reload), .timer_value(timer_value), .timer_ovf(timer_ovf),
  .chan_mode(chan_mode), .pin_in(pin_in), .pin_oe_n(pin_oe_n), .chan_irq(chan_irq));

// ==== dv/pin_partner.sv ====
// Far side: pin drivers, upstream timer pulse and external count lines
`timescale 1ns/1ps
module pin_partner
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Pins
  input wire logic [15:0] pin_req,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  output logic [15:0] pin_in,
  // Count sources
  output logic upstream_gp_timer_ovf,
  output logic [1:0] ext_count
);
  logic [2:0] tick;
  // The unit owns the wire where it drives, the outside world elsewhere
  assign pin_in = (pin_oe_n & pin_req) | (~pin_oe_n & pin_out);
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      tick <= 3'h0;
    else
      tick <= tick + 3'h1;
  // One pulse and one rising count edge every eight cycles, any phase
  assign upstream_gp_timer_ovf = (tick == 3'h7);
  assign ext_count = {2{tick[2]}};
endmodule

// ==== dv/capcom_unit_tb.sv ====
// Self-checking bench for the capture/compare unit
`timescale 1ns/1ps
module capcom_unit_tb;
  import capcom_pkg::*;
  logic ref_clk = 0;
  logic resetn = 0;
  logic [1:0] timer_run = 0;
  logic [1:0][2:0] timer_src = 0;
  logic [1:0][15:0] timer_reload = 0;
  logic staggered = 0;
  logic upstream_gp_timer_ovf;
  logic [1:0] ext_count;
  logic [15:0][3:0] chan_mode = 0;
  logic [15:0] chan_timer = 0;
  logic [15:0] single_event = 0;
  logic wr_en = 0;
  logic [3:0] wr_chan = 0;
  logic [15:0] wr_data = 0;
  logic [3:0] rd_chan = 0;
  logic [15:0] rd_data, pin_in, pin_out, pin_oe_n, chan_irq, single_done, last_pin;
  logic [15:0] pin_req = 0;
  logic [1:0][15:0] timer_value;
  logic [1:0] timer_ovf;
  int num_errors = 0, samples_checked = 0, cycles = 0, seed = 98, model1 = 0, tog4 = 0, tog7 = 0;
  int irq_cnt[16];
  int rise6 = 0;
  logic cnt_on = 0;
  logic cap0 = 0;
  logic [2:0] o = 0, n;
  capcom_unit dut_u (.ref_clk(ref_clk), .resetn(resetn), .timer_run(timer_run),
    .timer_src(timer_src), .timer_reload(timer_reload), .staggered(staggered),
    .upstream_gp_timer_ovf(upstream_gp_timer_ovf), .ext_count(ext_count), .chan_mode(chan_mode),
    .chan_timer(chan_timer), .single_event(single_event), .wr_en(wr_en), .wr_chan(wr_chan),
    .wr_data(wr_data), .rd_chan(rd_chan), .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .chan_irq(chan_irq), .timer_value(timer_value), .timer_ovf(timer_ovf),
    .single_done(single_done));
  pin_partner far_u (.ref_clk(ref_clk), .resetn(resetn), .pin_req(pin_req), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_in(pin_in), .upstream_gp_timer_ovf(upstream_gp_timer_ovf),
    .ext_count(ext_count));
  initial
    forever #4 ref_clk = ~ref_clk;
  // ==========================================================
  // Helpers
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task summarize;
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [3:0] c, input logic [15:0] d);
    @(posedge ref_clk);
    wr_en <= 1;
    wr_chan <= c;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 0;
  endtask
  task wait_ovf;
    int t;
    t = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      t++;
    end
    while (timer_ovf[0] !== 1'b1 && t < 70000);
    // A missing overflow is a failure even if the value happens to match
    if (t >= 70000)
      num_errors++;
    chk(timer_value[0], 16'hFFF0);
  endtask
  // Event counters over a period-aligned window
  always @(posedge ref_clk)
  begin
    cycles++;
    last_pin <= pin_out;
    if (cnt_on)
    begin
      for (int i = 0; i < 16; i++)
        irq_cnt[i] += int'(chan_irq[i]);
      tog4 += int'(pin_out[4] ^ last_pin[4]);
      tog7 += int'(pin_out[7] ^ last_pin[7]);
      rise6 += int'(pin_out[6] & ~last_pin[6]);
    end
    if (cycles > 80000)
    begin
      num_errors++;
      summarize;
    end
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1;
    timer_reload[0] <= 16'hFFF0;
    timer_run[0] <= 1;
    #1 chk(pin_oe_n, 16'hFFFF);
    // Timer 1 through every count source, then staggered
    for (int k = 0; k < 9; k++)
    begin
      @(posedge ref_clk);
      timer_src[1] <= 3'(k);
      staggered <= (k == 8);
      timer_run[1] <= 1;
      repeat (64) @(posedge ref_clk);
      timer_run[1] <= 0;
      staggered <= 0;
      repeat (2) @(posedge ref_clk);
      model1 += (k < 6) ? (64 >> k) : 8;
      #1 chk(timer_value[1], 16'(model1));
    end
    // Random pin edges on three capture channels tied to timer 1
    chan_mode[0] <= MODE_CAP_RISE;
    chan_mode[1] <= MODE_CAP_FALL;
    chan_mode[2] <= MODE_CAP_BOTH;
    chan_timer[2:0] <= 3'h7;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge ref_clk);
      n = 3'($random(seed));
      pin_req[2:0] <= n;
      @(posedge ref_clk);
      #1 chk(chan_irq, {13'h0, o[2] ^ n[2], o[1] & ~n[1], ~o[0] & n[0]});
      cap0 |= ~o[0] & n[0];
      o = n;
    end
    repeat (2) @(posedge ref_clk);
    #1 chk(rd_data, cap0 ? 16'(model1) : 16'h0000);
    // Compare channels on timer 0 with a sixteen-cycle period
    wait_ovf;
    for (int c = 3; c < 8; c++)
      wr(4'(c), 16'hFFF8);
    wr(4'hF, 16'hFFFC);
    chan_mode[3] <= MODE_CMP0;
    chan_mode[4] <= MODE_CMP1;
    chan_mode[5] <= MODE_CMP2;
    chan_mode[6] <= MODE_CMP3;
    chan_mode[7] <= MODE_DOUBLE;
    chan_mode[15] <= MODE_DOUBLE;
    wait_ovf;
    @(posedge ref_clk);
    single_event[3] <= 1;
    cnt_on <= 1;
    repeat (64) @(posedge ref_clk);
    cnt_on <= 0;
    #1 chk(16'(irq_cnt[3]), 16'h0001);
    chk(16'(irq_cnt[4]), 16'h0004);
    chk(16'(irq_cnt[5]), 16'h0004);
    chk(16'(irq_cnt[6]), 16'h0004);
    chk(16'(tog4), 16'h0004);
    chk(16'(tog7), 16'h0008);
    chk({15'h0, single_done[3]}, 16'h0001);
    chk(16'(rise6), 16'h0004);
    chk({15'h0, pin_out[6]}, 16'h0000);
    // Second match inside one period: mode 0 fires again, mode 2 stays quiet
    single_event[3] <= 0;
    wait_ovf;
    cnt_on <= 1;
    repeat (7) @(posedge ref_clk);
    wr(4'h3, 16'hFFFC);
    wr(4'h5, 16'hFFFC);
    repeat (8) @(posedge ref_clk);
    cnt_on <= 0;
    #1 chk(16'(irq_cnt[3]), 16'h0003);
    chk(16'(irq_cnt[5]), 16'h0005);
    summarize;
  end
endmodule
